// ### rfa_pkg.sv
package rfa_pkg;

  // Control region locations of the pointer registers.
  localparam logic [7:0] RFA_LOW_SLICE_OFS  = 8'hd6;
  localparam logic [7:0] RFA_HIGH_SLICE_OFS = 8'hd7;
  localparam logic [7:0] RFA_STACK_OFS      = 8'hd9;

  // Reset values; the stack pointer is undefined on silicon, so a neutral zero is used.
  localparam logic [7:0] RFA_LOW_SLICE_RST  = 8'hc0;
  localparam logic [7:0] RFA_HIGH_SLICE_RST = 8'hc8;
  localparam logic [7:0] RFA_STACK_RST      = 8'h00;

  // Address map landmarks and field positions.
  localparam logic [7:0] RFA_UPPER_BASE  = 8'hc0;
  localparam logic [3:0] RFA_WREG_NIBBLE = 4'hc;
  localparam int         RFA_SEL_BIT     = 3;

  typedef enum logic [1:0] {
    RFA_MODE_WREG4    = 2'b00,
    RFA_MODE_DIRECT   = 2'b01,
    RFA_MODE_INDIRECT = 2'b10,
    RFA_MODE_INDEXED  = 2'b11
  } rfa_mode_type;

  typedef enum logic [1:0] {
    RFA_SRP_BOTH = 2'b00,
    RFA_SRP_LOW  = 2'b01,
    RFA_SRP_HIGH = 2'b10
  } rfa_srp_sel_type;

  typedef enum logic [2:0] {
    RFA_STK_PUSH = 3'b000,
    RFA_STK_POP  = 3'b001,
    RFA_STK_CALL = 3'b010,
    RFA_STK_RET  = 3'b011,
    RFA_STK_INT  = 3'b100,
    RFA_STK_INTERRUPT_RETURN_INSTR = 3'b101
  } rfa_stk_cmd_type;

  typedef enum logic [1:0] {
    RFA_USER_PUSH_INCREMENT = 2'b00,
    RFA_USER_PUSH_DECREMENT = 2'b01,
    RFA_USER_POP_INCREMENT  = 2'b10,
    RFA_USER_POP_DECREMENT  = 2'b11
  } rfa_usr_cmd_type;

  typedef enum logic [1:0] {
    RFA_SRC_DATA  = 2'b00,
    RFA_SRC_PC_LO = 2'b01,
    RFA_SRC_PC_HI = 2'b10,
    RFA_SRC_FLAGS = 2'b11
  } rfa_src_type;

  typedef struct packed {logic valid; rfa_mode_type mode; logic [7:0] addr; logic pair;} rfa_op_req_type;
  typedef struct packed {logic valid; logic working; logic set2; logic [7:0] addr_hi; logic [7:0] addr_lo;} rfa_op_resp_type;
  typedef struct packed {logic valid; logic [7:0] addr; logic [7:0] data;} rfa_wr_type;
  typedef struct packed {logic valid; rfa_srp_sel_type sel; logic [7:0] data;} rfa_srp_type;
  typedef struct packed {logic valid; rfa_stk_cmd_type cmd;} rfa_stk_req_type;
  typedef struct packed {logic valid; logic write; rfa_src_type src; logic [7:0] addr;} rfa_stk_resp_type;
  typedef struct packed {logic valid; rfa_usr_cmd_type cmd; logic [7:0] ptr;} rfa_usr_req_type;
  typedef struct packed {logic valid; logic write; logic [7:0] addr; logic [7:0] ptr;} rfa_usr_resp_type;
  typedef struct packed {logic [7:0] low_slice; logic [7:0] high_slice; logic [7:0] stack_top;} rfa_ptrs_type;
  typedef struct packed {logic [1:0] cnt; logic push; logic [5:0] srcs;} rfa_seq_type;

endpackage

// ### rfa_addr_unit.sv
`timescale 1ns/10ps
// Functional notes
// - Addresses 00h to BFh resolve unchanged in direct, indirect and indexed modes.
// - The prime area needs no setup after reset.
// - Working addressing sees the file as 32 slices sharing upper five bits.
// - Two 8-bit slice pointers form a relocatable sixteen register block.
// - Low slice pointer sits at D6h, high slice pointer at D7h.
// - Reset points low slice at C0h and high slice at C8h.
// - Pointers change by slice-set instruction or by ordinary register load.
// - Working register accesses never land in the duplicated upper set.
// - Direct addressing reaches every location except the duplicated upper set.
// - Register pairs start even, high byte even, low byte next odd.
// - Top bit of a 4-bit field picks low or high slice pointer.
// - Address is pointer bits 7..3 joined with field bits 2..0.
// - An 8-bit direct operand with upper nibble 1100b is working register addressing.
// - The system stack lives in the register file with byte push and pop.
// - Call pushes the program counter; return pops it back.
// - Interrupt pushes program counter and flags; interrupt return pops both.
// - Stack pointer decrements before each push, increments after each pop.
// - Stack pointer always addresses the most recently pushed byte.
// - Four user stack operations: push and pop, each incrementing or decrementing.
// - Stack pointer is an 8-bit register at D9h.
// - Direct D0h-FFh goes to control set; indirect or indexed C0h-FFh goes to set 2.
module rfa_addr_unit (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire rfa_pkg::rfa_op_req_type   op_req,
  input  wire rfa_pkg::rfa_wr_type       wr_req,
  input  wire rfa_pkg::rfa_srp_type      srp_req,
  input  wire rfa_pkg::rfa_stk_req_type  stk_req,
  input  wire rfa_pkg::rfa_usr_req_type  usr_req,
  output rfa_pkg::rfa_op_resp_type       op_resp,
  output rfa_pkg::rfa_stk_resp_type      stk_resp,
  output rfa_pkg::rfa_usr_resp_type      usr_resp,
  output rfa_pkg::rfa_ptrs_type          ptrs,
  output logic                           stk_busy
);

  typedef enum logic [1:0] {
    RFA_ST_IDLE    = 2'b00,
    RFA_ST_PUSHING = 2'b01,
    RFA_ST_POPPING = 2'b10
  } rfa_state_type;

  logic [7:0]                low_slice_pointer_reg;
  logic [7:0]                high_slice_pointer_reg;
  logic [7:0]                stack_top_pointer_reg;
  rfa_state_type             state_reg;
  logic [1:0]                cnt_reg;
  logic [5:0]                srcs_reg;
  logic                      busy_reg;
  rfa_pkg::rfa_op_resp_type  op_resp_reg;
  rfa_pkg::rfa_op_resp_type  op_resp_next;
  rfa_pkg::rfa_stk_resp_type stk_resp_reg;
  rfa_pkg::rfa_usr_resp_type usr_resp_reg;
  rfa_pkg::rfa_usr_resp_type usr_resp_next;
  rfa_pkg::rfa_seq_type      seq_next;
  logic                      emit;
  logic                      emit_push;
  logic [7:0]                base_addr;

  // Joins a slice pointer with the register number inside the slice.
  function automatic logic [7:0] wreg_addr(input logic [7:0] lo_p, input logic [7:0] hi_p, input logic [3:0] f);
    wreg_addr = f[rfa_pkg::RFA_SEL_BIT] ? {hi_p[7:3], f[2:0]} : {lo_p[7:3], f[2:0]};
  endfunction

  // One step of a byte pointer, wrapping around the 256-byte file.
  function automatic logic [7:0] step8(input logic [7:0] v, input logic up);
    step8 = up ? v + 8'h01 : v - 8'h01;
  endfunction

  // Byte order of each system stack command; the first byte sits in the low source slot.
  function automatic rfa_pkg::rfa_seq_type seq_for(input rfa_pkg::rfa_stk_cmd_type c);
    seq_for = '0;
    case (c)
      rfa_pkg::RFA_STK_PUSH: seq_for = '{2'h1, 1'b1, {4'h0, rfa_pkg::RFA_SRC_DATA}};
      rfa_pkg::RFA_STK_POP:  seq_for = '{2'h1, 1'b0, {4'h0, rfa_pkg::RFA_SRC_DATA}};
      rfa_pkg::RFA_STK_CALL: seq_for = '{2'h2, 1'b1, {2'h0, rfa_pkg::RFA_SRC_PC_HI, rfa_pkg::RFA_SRC_PC_LO}};
      rfa_pkg::RFA_STK_RET:  seq_for = '{2'h2, 1'b0, {2'h0, rfa_pkg::RFA_SRC_PC_LO, rfa_pkg::RFA_SRC_PC_HI}};
      rfa_pkg::RFA_STK_INT:  seq_for = '{2'h3, 1'b1,
        {rfa_pkg::RFA_SRC_FLAGS, rfa_pkg::RFA_SRC_PC_HI, rfa_pkg::RFA_SRC_PC_LO}};
      rfa_pkg::RFA_STK_INTERRUPT_RETURN_INSTR: seq_for = '{2'h3, 1'b0,
        {rfa_pkg::RFA_SRC_PC_LO, rfa_pkg::RFA_SRC_PC_HI, rfa_pkg::RFA_SRC_FLAGS}};
      default:               seq_for = '0;
    endcase
  endfunction

  // Operand address resolution; pointer bits 2..0 are never read here.
  always_comb begin
    op_resp_next       = '0;
    op_resp_next.valid = op_req.valid;
    base_addr          = op_req.addr;
    unique case (op_req.mode)
      rfa_pkg::RFA_MODE_WREG4: begin
        op_resp_next.working = 1'b1;
        base_addr = wreg_addr(low_slice_pointer_reg, high_slice_pointer_reg, op_req.addr[3:0]);
      end
      rfa_pkg::RFA_MODE_DIRECT: begin
        if (op_req.addr[7:4] == rfa_pkg::RFA_WREG_NIBBLE) begin
          op_resp_next.working = 1'b1;
          base_addr = wreg_addr(low_slice_pointer_reg, high_slice_pointer_reg, op_req.addr[3:0]);
        end
      end
      rfa_pkg::RFA_MODE_INDIRECT, rfa_pkg::RFA_MODE_INDEXED: begin
        op_resp_next.set2 = (op_req.addr >= rfa_pkg::RFA_UPPER_BASE);
      end
    endcase
    // Direct accesses outside the working window keep the address and the control set.
    if (op_req.pair) begin
      op_resp_next.addr_hi = {base_addr[7:1], 1'b0};
      op_resp_next.addr_lo = {base_addr[7:1], 1'b1};
    end else begin
      op_resp_next.addr_hi = base_addr;
      op_resp_next.addr_lo = base_addr;
    end
  end

  // Resolved address is registered so the core sees it one cycle after the request.
  always_ff @(posedge mclk) begin
    if (reset) begin
      op_resp_reg <= '0;
    end else begin
      op_resp_reg <= op_resp_next;
    end
  end

  // Slice pointers; the set instruction wins over a plain load in the same cycle.
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_slice_pointer_reg  <= rfa_pkg::RFA_LOW_SLICE_RST;
      high_slice_pointer_reg <= rfa_pkg::RFA_HIGH_SLICE_RST;
    end else if (srp_req.valid) begin
      case (srp_req.sel)
        rfa_pkg::RFA_SRP_BOTH: begin
          low_slice_pointer_reg  <= {srp_req.data[7:4], 1'b0, srp_req.data[2:0]};
          high_slice_pointer_reg <= {srp_req.data[7:4], 1'b1, srp_req.data[2:0]};
        end
        rfa_pkg::RFA_SRP_LOW:  low_slice_pointer_reg  <= srp_req.data;
        rfa_pkg::RFA_SRP_HIGH: high_slice_pointer_reg <= srp_req.data;
        default:               low_slice_pointer_reg  <= low_slice_pointer_reg;
      endcase
    end else if (wr_req.valid) begin
      if (wr_req.addr == rfa_pkg::RFA_LOW_SLICE_OFS) begin
        low_slice_pointer_reg <= wr_req.data;
      end
      if (wr_req.addr == rfa_pkg::RFA_HIGH_SLICE_OFS) begin
        high_slice_pointer_reg <= wr_req.data;
      end
    end
  end

  assign seq_next  = seq_for(stk_req.cmd);
  assign emit      = (state_reg != RFA_ST_IDLE);
  assign emit_push = (state_reg == RFA_ST_PUSHING);

  // System stack sequencer: one byte per cycle, requests ignored while busy.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= RFA_ST_IDLE;
      cnt_reg   <= 2'h0;
      srcs_reg  <= 6'h00;
      busy_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        RFA_ST_IDLE: begin
          if (stk_req.valid && seq_next.cnt != 2'h0) begin
            state_reg <= seq_next.push ? RFA_ST_PUSHING : RFA_ST_POPPING;
            cnt_reg   <= seq_next.cnt;
            srcs_reg  <= seq_next.srcs;
            busy_reg  <= 1'b1;
          end
        end
        RFA_ST_PUSHING, RFA_ST_POPPING: begin
          srcs_reg <= {2'h0, srcs_reg[5:2]};
          cnt_reg  <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h1) begin
            state_reg <= RFA_ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        default: begin
          state_reg <= RFA_ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Stack pointer: push pre-decrements, pop post-increments; a load is refused while a sequence runs.
  always_ff @(posedge mclk) begin
    if (reset) begin
      stack_top_pointer_reg <= rfa_pkg::RFA_STACK_RST;
    end else if (emit) begin
      stack_top_pointer_reg <= step8(stack_top_pointer_reg, !emit_push);
    end else if (wr_req.valid && wr_req.addr == rfa_pkg::RFA_STACK_OFS) begin
      stack_top_pointer_reg <= wr_req.data;
    end
  end

  // Stack byte address; after a push the pointer equals the address just written.
  always_ff @(posedge mclk) begin
    if (reset) begin
      stk_resp_reg <= '0;
    end else begin
      stk_resp_reg.valid <= emit;
      stk_resp_reg.write <= emit_push;
      stk_resp_reg.src   <= rfa_pkg::rfa_src_type'(srcs_reg[1:0]);
      stk_resp_reg.addr  <= emit_push ? step8(stack_top_pointer_reg, 1'b0) : stack_top_pointer_reg;
    end
  end

  // User stacks keep their pointer in an ordinary register, so the core supplies it and stores it back.
  always_comb begin
    usr_resp_next       = '0;
    usr_resp_next.valid = usr_req.valid;
    unique case (usr_req.cmd)
      rfa_pkg::RFA_USER_PUSH_INCREMENT: begin
        usr_resp_next.write = 1'b1;
        usr_resp_next.ptr   = step8(usr_req.ptr, 1'b1);
        usr_resp_next.addr  = usr_resp_next.ptr;
      end
      rfa_pkg::RFA_USER_PUSH_DECREMENT: begin
        usr_resp_next.write = 1'b1;
        usr_resp_next.ptr   = step8(usr_req.ptr, 1'b0);
        usr_resp_next.addr  = usr_resp_next.ptr;
      end
      rfa_pkg::RFA_USER_POP_INCREMENT: begin
        usr_resp_next.addr = usr_req.ptr;
        usr_resp_next.ptr  = step8(usr_req.ptr, 1'b1);
      end
      rfa_pkg::RFA_USER_POP_DECREMENT: begin
        usr_resp_next.addr = usr_req.ptr;
        usr_resp_next.ptr  = step8(usr_req.ptr, 1'b0);
      end
    endcase
  end

  // User stack answer register.
  always_ff @(posedge mclk) begin
    if (reset) begin
      usr_resp_reg <= '0;
    end else begin
      usr_resp_reg <= usr_resp_next;
    end
  end

  // Outputs come straight from flops.
  assign op_resp  = op_resp_reg;
  assign stk_resp = stk_resp_reg;
  assign usr_resp = usr_resp_reg;
  assign stk_busy = busy_reg;
  assign ptrs     = '{low_slice_pointer_reg, high_slice_pointer_reg, stack_top_pointer_reg};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_call_taken;
    stk_req.valid && !busy_reg && stk_req.cmd == rfa_pkg::RFA_STK_CALL;
  endsequence
  sequence s_pc_pushed;
    stk_resp_reg.valid && stk_resp_reg.write && stk_resp_reg.src == rfa_pkg::RFA_SRC_PC_LO ##1
    stk_resp_reg.valid && stk_resp_reg.write && stk_resp_reg.src == rfa_pkg::RFA_SRC_PC_HI;
  endsequence
  sequence s_int_taken;
    stk_req.valid && !busy_reg && stk_req.cmd == rfa_pkg::RFA_STK_INT;
  endsequence
  sequence s_flags_pushed;
    stk_resp_reg.valid && stk_resp_reg.write && stk_resp_reg.src == rfa_pkg::RFA_SRC_FLAGS ##1 !busy_reg;
  endsequence
  sequence s_ret_taken;
    stk_req.valid && !busy_reg && stk_req.cmd == rfa_pkg::RFA_STK_RET;
  endsequence
  sequence s_pc_popped;
    stk_resp_reg.valid && !stk_resp_reg.write && stk_resp_reg.src == rfa_pkg::RFA_SRC_PC_HI ##1
    stk_resp_reg.valid && !stk_resp_reg.write && stk_resp_reg.src == rfa_pkg::RFA_SRC_PC_LO;
  endsequence
  sequence s_interrupt_return_instr_taken;
    stk_req.valid && !busy_reg && stk_req.cmd == rfa_pkg::RFA_STK_INTERRUPT_RETURN_INSTR;
  endsequence

  a_reset_slices: assert property ($fell(reset) |-> low_slice_pointer_reg == 8'hc0 && high_slice_pointer_reg == 8'hc8)
    else $error("slice pointers wrong after reset");
  a_wreg4_form: assert property (op_req.valid && op_req.mode == rfa_pkg::RFA_MODE_WREG4 && !op_req.pair |=>
    op_resp_reg.working && op_resp_reg.addr_hi[2:0] == $past(op_req.addr[2:0]) &&
    op_resp_reg.addr_hi[7:3] == ($past(op_req.addr[3]) ? $past(high_slice_pointer_reg[7:3])
                                                        : $past(low_slice_pointer_reg[7:3])))
    else $error("4-bit working address formed wrongly");
  a_wreg8_form: assert property (op_req.valid && op_req.mode == rfa_pkg::RFA_MODE_DIRECT &&
    op_req.addr[7:4] == 4'hc && op_req.addr[3] && !op_req.pair |=>
    op_resp_reg.working && op_resp_reg.addr_hi == {$past(high_slice_pointer_reg[7:3]), $past(op_req.addr[2:0])})
    else $error("8-bit working address formed wrongly");
  a_prime_open: assert property (op_req.valid && op_req.mode != rfa_pkg::RFA_MODE_WREG4 &&
    op_req.addr < 8'hc0 && !op_req.pair |=> op_resp_reg.addr_hi == $past(op_req.addr) && !op_resp_reg.set2)
    else $error("prime area address altered");
  a_working_set1: assert property (op_resp_reg.valid && op_resp_reg.working |-> !op_resp_reg.set2)
    else $error("working access reached set 2");
  a_set_routing: assert property (op_req.valid && op_req.addr >= 8'hd0 &&
    (op_req.mode == rfa_pkg::RFA_MODE_INDIRECT || op_req.mode == rfa_pkg::RFA_MODE_INDEXED) |=> op_resp_reg.set2)
    else $error("indirect upper access not routed to set 2");
  a_direct_set1: assert property (op_req.valid && op_req.mode == rfa_pkg::RFA_MODE_DIRECT &&
    op_req.addr >= 8'hd0 && !op_req.pair |=> !op_resp_reg.set2 && op_resp_reg.addr_hi == $past(op_req.addr))
    else $error("direct upper access misrouted");
  a_pair_even: assert property (op_req.valid && op_req.pair |=>
    !op_resp_reg.addr_hi[0] && op_resp_reg.addr_lo == {op_resp_reg.addr_hi[7:1], 1'b1})
    else $error("register pair misaligned");
  a_push_top: assert property (stk_resp_reg.valid && stk_resp_reg.write |->
    stk_resp_reg.addr == stack_top_pointer_reg && $past(stack_top_pointer_reg) == step8(stk_resp_reg.addr, 1'b1))
    else $error("push not pre-decremented");
  a_pop_after: assert property (stk_resp_reg.valid && !stk_resp_reg.write |->
    stack_top_pointer_reg == step8(stk_resp_reg.addr, 1'b1))
    else $error("pop not post-incremented");
  a_call_saves_pc: assert property (s_call_taken |-> ##2 s_pc_pushed)
    else $error("call did not push the program counter");
  a_int_saves_all: assert property (s_int_taken |-> ##2 s_pc_pushed ##1 s_flags_pushed)
    else $error("interrupt entry push sequence wrong");
  a_srp_low: assert property (srp_req.valid && srp_req.sel == rfa_pkg::RFA_SRP_LOW |=>
    low_slice_pointer_reg == $past(srp_req.data))
    else $error("slice-set instruction ignored");
  a_user_push_dec: assert property (usr_req.valid && usr_req.cmd == rfa_pkg::RFA_USER_PUSH_DECREMENT |=>
    usr_resp_reg.write && usr_resp_reg.addr == step8($past(usr_req.ptr), 1'b0) && usr_resp_reg.ptr == usr_resp_reg.addr)
    else $error("user push decrement wrong");
  a_ret_restores_pc: assert property (s_ret_taken |-> ##2 s_pc_popped)
    else $error("return did not pop the program counter");
  a_interrupt_return_instr_restores_all: assert property (s_interrupt_return_instr_taken |-> ##2 stk_resp_reg.valid && !stk_resp_reg.write &&
    stk_resp_reg.src == rfa_pkg::RFA_SRC_FLAGS ##1 s_pc_popped)
    else $error("interrupt return pop sequence wrong");
  a_stack_load: assert property (wr_req.valid && wr_req.addr == rfa_pkg::RFA_STACK_OFS &&
    state_reg == RFA_ST_IDLE |=> stack_top_pointer_reg == $past(wr_req.data))
    else $error("stack pointer load lost");
  a_low_load: assert property (wr_req.valid && wr_req.addr == rfa_pkg::RFA_LOW_SLICE_OFS &&
    !srp_req.valid |=> low_slice_pointer_reg == $past(wr_req.data))
    else $error("low slice pointer load lost");
  a_srp_both: assert property (srp_req.valid && srp_req.sel == rfa_pkg::RFA_SRP_BOTH |=>
    low_slice_pointer_reg[7:3] == {$past(srp_req.data[7:4]), 1'b0} &&
    high_slice_pointer_reg[7:3] == {$past(srp_req.data[7:4]), 1'b1})
    else $error("slice pair set wrongly");
  a_wreg8_low: assert property (op_req.valid && op_req.mode == rfa_pkg::RFA_MODE_DIRECT &&
    op_req.addr[7:4] == rfa_pkg::RFA_WREG_NIBBLE && !op_req.addr[3] && !op_req.pair |=>
    op_resp_reg.working && op_resp_reg.addr_hi == {$past(low_slice_pointer_reg[7:3]), $past(op_req.addr[2:0])})
    else $error("8-bit working address in low slice wrong");
  a_user_pop_inc: assert property (usr_req.valid && usr_req.cmd == rfa_pkg::RFA_USER_POP_INCREMENT |=>
    !usr_resp_reg.write && usr_resp_reg.addr == $past(usr_req.ptr) && usr_resp_reg.ptr == $past(usr_req.ptr) + 8'h01)
    else $error("user pop increment wrong");

endmodule

// ### rfa_core_model.sv
`timescale 1ns/10ps
// Stand-in for the core's decoder and execute stage that issues address requests.
module rfa_core_model (
  input  wire logic                      mclk,
  output rfa_pkg::rfa_op_req_type        op_req,
  output rfa_pkg::rfa_wr_type            wr_req,
  output rfa_pkg::rfa_srp_type           srp_req,
  output rfa_pkg::rfa_stk_req_type       stk_req,
  output rfa_pkg::rfa_usr_req_type       usr_req,
  input  wire rfa_pkg::rfa_op_resp_type  op_resp,
  input  wire rfa_pkg::rfa_stk_resp_type stk_resp,
  input  wire rfa_pkg::rfa_usr_resp_type usr_resp
);
  // All requests start idle so nothing is taken during reset.
  initial begin
    op_req  = '0;
    wr_req  = '0;
    srp_req = '0;
    stk_req = '0;
    usr_req = '0;
  end

  // Direct operands in the common area are normally sent in working form; the bench also sends two raw.
  task automatic op(input rfa_pkg::rfa_mode_type m, input logic [7:0] a, input logic p,
                    output rfa_pkg::rfa_op_resp_type r);
    @(negedge mclk);
    op_req <= '{1'b1, m, a, p};
    @(negedge mclk);
    r = op_resp;
    op_req <= '{1'b0, m, ~a, ~p}; // Released fields flip so stale values cannot pass.
  endtask

  // Slice pointer set instruction, one cycle wide.
  task automatic set_slice_pointer_instr(input rfa_pkg::rfa_srp_sel_type s, input logic [7:0] d);
    @(negedge mclk);
    srp_req <= '{1'b1, s, d};
    @(negedge mclk);
    srp_req <= '{1'b0, s, ~d};
  endtask

  // Ordinary register load into the control region.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr_req <= '{1'b1, a, d};
    @(negedge mclk);
    wr_req <= '{1'b0, ~a, ~d};
  endtask

  // System stack request; collects n bytes after a bounded wait for the first.
  task automatic stk(input rfa_pkg::rfa_stk_cmd_type c, input int n, output rfa_pkg::rfa_stk_resp_type r [3]);
    int k;
    @(negedge mclk);
    stk_req <= '{1'b1, c};
    @(negedge mclk);
    stk_req <= '{1'b0, c};
    for (k = 0; k < 8 && stk_resp.valid !== 1'b1; k++) @(negedge mclk);
    for (k = 0; k < n; k++) begin
      r[k] = stk_resp;
      @(negedge mclk);
    end
  endtask

  // User stack request with the current user pointer.
  task automatic usr(input rfa_pkg::rfa_usr_cmd_type c, input logic [7:0] p, output rfa_pkg::rfa_usr_resp_type r);
    @(negedge mclk);
    usr_req <= '{1'b1, c, p};
    @(negedge mclk);
    r = usr_resp;
    usr_req <= '{1'b0, c, ~p};
  endtask
endmodule

// ### register_file_addressing_unit_test.sv
`timescale 1ns/10ps
// Self-checking bench for the register file addressing unit.
module register_file_addressing_unit_test;
  logic                       mclk;
  logic                       reset;
  rfa_pkg::rfa_op_req_type    op_req;
  rfa_pkg::rfa_wr_type        wr_req;
  rfa_pkg::rfa_srp_type       srp_req;
  rfa_pkg::rfa_stk_req_type   stk_req;
  rfa_pkg::rfa_usr_req_type   usr_req;
  rfa_pkg::rfa_op_resp_type   op_resp;
  rfa_pkg::rfa_stk_resp_type  stk_resp;
  rfa_pkg::rfa_usr_resp_type  usr_resp;
  rfa_pkg::rfa_ptrs_type      ptrs;
  logic                       stk_busy;
  int                         error_cnt = 0;
  int                         check_count = 0;
  logic [7:0]                 sp;
  rfa_pkg::rfa_op_resp_type   ro;
  rfa_pkg::rfa_usr_resp_type  ru;
  rfa_pkg::rfa_stk_resp_type  rs [3];
  rfa_pkg::rfa_stk_cmd_type   s_cmd [6] = '{rfa_pkg::RFA_STK_PUSH, rfa_pkg::RFA_STK_POP, rfa_pkg::RFA_STK_CALL,
                                            rfa_pkg::RFA_STK_RET, rfa_pkg::RFA_STK_INT, rfa_pkg::RFA_STK_INTERRUPT_RETURN_INSTR};
  int                         s_len [6] = '{1, 1, 2, 2, 3, 3};
  logic [5:0]                 s_src [6] = '{6'h00, 6'h00, 6'h09, 6'h06, 6'h39, 6'h1b};
  logic                       s_wr [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [7:0]                 u_addr [4] = '{8'h41, 8'h3f, 8'h40, 8'h40};
  logic [7:0]                 u_ptr [4] = '{8'h41, 8'h3f, 8'h41, 8'h3f};

  // Free-running core clock at 100 MHz.
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  rfa_addr_unit dut_u (
    .mclk     (mclk),
    .reset    (reset),
    .op_req   (op_req),
    .wr_req   (wr_req),
    .srp_req  (srp_req),
    .stk_req  (stk_req),
    .usr_req  (usr_req),
    .op_resp  (op_resp),
    .stk_resp (stk_resp),
    .usr_resp (usr_resp),
    .ptrs     (ptrs),
    .stk_busy (stk_busy)
  );

  rfa_core_model core_u (
    .mclk     (mclk),
    .op_req   (op_req),
    .wr_req   (wr_req),
    .srp_req  (srp_req),
    .stk_req  (stk_req),
    .usr_req  (usr_req),
    .op_resp  (op_resp),
    .stk_resp (stk_resp),
    .usr_resp (usr_resp)
  );

  // One compare point so every check is counted and reported alike.
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run; also reached by the watchdog.
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Operand request with the whole expected response compared at once.
  task automatic op_chk(input rfa_pkg::rfa_mode_type m, input logic [7:0] a, input logic p,
                        input logic w, input logic s, input logic [7:0] h, input logic [7:0] l);
    rfa_pkg::rfa_op_resp_type e;
    e = '{1'b1, w, s, h, l};
    core_u.op(m, a, p, ro);
    check("op_resp", 24'(ro), 24'(e));
  endtask

  // Stack sequence; the expected pointer walk is worked out byte by byte.
  task automatic stk_chk(input int i);
    int k;
    rfa_pkg::rfa_stk_resp_type e;
    // Busy must be up in the cycle after the request is taken.
    fork
      core_u.stk(s_cmd[i], s_len[i], rs);
      begin
        repeat (2) @(negedge mclk);
        check("stk_busy", 24'(stk_busy), 24'h1);
      end
    join
    for (k = 0; k < s_len[i]; k++) begin
      if (s_wr[i]) sp = sp - 8'h01;
      e = '{1'b1, s_wr[i], rfa_pkg::rfa_src_type'(s_src[i][2*k +: 2]), sp};
      if (!s_wr[i]) sp = sp + 8'h01;
      check("stk_resp", 24'(rs[k]), 24'(e));
    end
    check("stack_top", 24'(ptrs.stack_top), 24'(sp));
    check("stk_busy", 24'(stk_busy), 24'h0);
  endtask

  // Watchdog: the tests need about a hundred cycles, so 2000 means a hang.
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end

  // Main sequence of address, pointer and stack tests.
  initial begin
    reset = 1'b1;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    check("ptrs", 24'(ptrs), 24'hc0c800);
    check("stk_busy", 24'(stk_busy), 24'h0);
    op_chk(rfa_pkg::RFA_MODE_WREG4, 8'h06, 1'b0, 1'b1, 1'b0, 8'hc6, 8'hc6);
    op_chk(rfa_pkg::RFA_MODE_WREG4, 8'h0e, 1'b0, 1'b1, 1'b0, 8'hce, 8'hce);
    op_chk(rfa_pkg::RFA_MODE_DIRECT, 8'h45, 1'b0, 1'b0, 1'b0, 8'h45, 8'h45);
    op_chk(rfa_pkg::RFA_MODE_INDIRECT, 8'hbf, 1'b0, 1'b0, 1'b0, 8'hbf, 8'hbf);
    op_chk(rfa_pkg::RFA_MODE_INDEXED, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    op_chk(rfa_pkg::RFA_MODE_DIRECT, 8'he5, 1'b0, 1'b0, 1'b0, 8'he5, 8'he5);
    op_chk(rfa_pkg::RFA_MODE_INDIRECT, 8'he5, 1'b0, 1'b0, 1'b1, 8'he5, 8'he5);
    op_chk(rfa_pkg::RFA_MODE_INDEXED, 8'hc4, 1'b0, 1'b0, 1'b1, 8'hc4, 8'hc4);
    op_chk(rfa_pkg::RFA_MODE_DIRECT, 8'h45, 1'b1, 1'b0, 1'b0, 8'h44, 8'h45);
    op_chk(rfa_pkg::RFA_MODE_DIRECT, 8'hc3, 1'b0, 1'b1, 1'b0, 8'hc3, 8'hc3);
    core_u.set_slice_pointer_instr(rfa_pkg::RFA_SRP_LOW, 8'h77);
    op_chk(rfa_pkg::RFA_MODE_WREG4, 8'h06, 1'b0, 1'b1, 1'b0, 8'h76, 8'h76);
    core_u.set_slice_pointer_instr(rfa_pkg::RFA_SRP_HIGH, 8'ha8);
    op_chk(rfa_pkg::RFA_MODE_DIRECT, 8'hcb, 1'b0, 1'b1, 1'b0, 8'hab, 8'hab);
    op_chk(rfa_pkg::RFA_MODE_WREG4, 8'h0f, 1'b1, 1'b1, 1'b0, 8'hae, 8'haf);
    core_u.set_slice_pointer_instr(rfa_pkg::RFA_SRP_LOW, 8'he0);
    op_chk(rfa_pkg::RFA_MODE_WREG4, 8'h01, 1'b0, 1'b1, 1'b0, 8'he1, 8'he1);
    core_u.set_slice_pointer_instr(rfa_pkg::RFA_SRP_BOTH, 8'h25);
    check("ptrs", 24'(ptrs), 24'h252d00);
    core_u.wr(8'hd6, 8'h40);
    core_u.wr(8'hd7, 8'h58);
    core_u.wr(8'hd8, 8'h11);
    check("ptrs", 24'(ptrs), 24'h405800);
    op_chk(rfa_pkg::RFA_MODE_WREG4, 8'h0a, 1'b0, 1'b1, 1'b0, 8'h5a, 8'h5a);
    core_u.wr(8'hd9, 8'hff);
    sp = 8'hff;
    check("stack_top", 24'(ptrs.stack_top), 24'hff);
    for (int i = 0; i < 6; i++) stk_chk(i);
    for (int i = 0; i < 4; i++) begin
      core_u.usr(rfa_pkg::rfa_usr_cmd_type'(i[1:0]), 8'h40, ru);
      check("usr_resp", 24'(ru), 24'({1'b1, ~i[1], u_addr[i], u_ptr[i]}));
    end
    finish_test();
  end
endmodule
